// *** rtl/scc_pkg.sv ***
/*
 * Constants, register map and carrier types of the speed command
 * conditioning block. Assumes a 100 MHz APB clock and an external ADC
 * that delivers the command in signed millivolts.
 */
package scc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_ZCLAMP = 8'h08;
    localparam logic [7:0] OFS_COIN = 8'h0c;
    localparam logic [7:0] OFS_ROT = 8'h10;
    localparam logic [7:0] OFS_MAXSPD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_TARGET = 8'h1c;

    // ==========================================================
    // Control field positions
    localparam int CTRL_SPEED_MODE = 0;
    localparam int CTRL_INV_ALLOC = 1;
    localparam int CTRL_RUN_ALLOC = 2;
    localparam int CTRL_COIN_ALLOC = 3;
    localparam int CTRL_ROT_ALLOC = 4;
    localparam int CTRL_ZC_LSB = 8;
    localparam int CTRL_ZC_W = 4;
    localparam logic [3:0] ZC_NEVER = 4'h0;
    localparam logic [3:0] ZC_ALWAYS = 4'h8;

    // ==========================================================
    // Reset values and ranges (gain in 0.1 RPM/V)
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] GAIN_RST = 16'h1388;
    localparam logic [15:0] GAIN_MIN = 16'h0064;
    localparam logic [15:0] GAIN_MAX = 16'h4e20;
    localparam logic [15:0] ZCLAMP_RST = 16'h0000;
    localparam logic [15:0] ZCLAMP_MIN = 16'h0000;
    localparam logic [15:0] ZCLAMP_MAX = 16'h1388;
    localparam logic [15:0] COIN_RST = 16'h000a;
    localparam logic [15:0] COIN_MIN = 16'h0001;
    localparam logic [15:0] COIN_MAX = 16'h03e8;
    localparam logic [15:0] ROT_RST = 16'h0014;
    localparam logic [15:0] ROT_MIN = 16'h0001;
    localparam logic [15:0] ROT_MAX = 16'h1388;
    localparam logic [15:0] MAXSPD_RST = 16'h1388;
    // mV times 0.1 RPM/V to RPM
    localparam logic signed [33:0] SCALE_DIV = 34'sh0_0000_2710;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic servo_on;
        logic zero_clamp_input;
        logic dir_invert_input;
        logic run_enable_input;
    } scc_seq_in_t;

    typedef struct packed {
        logic speed_coincidence_out;
        logic rotation_detect_out;
        logic over_speed_command_warning;
        logic line_indication_1;
    } scc_seq_out_t;

endpackage

// *** rtl/scc_speed_cmd.sv ***
/*
 * Speed command conditioning: scales the analog command, applies zero
 * clamp, direction invert and run gating to speed_target in speed mode, and drives the coincidence,
 * rotation and over-speed status. Assumes ADC samples and speed
 * feedback synchronous to pclk; registers reached over APB.
 */
`timescale 1ns/1ns
module scc_speed_cmd
    import scc_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog command (mV) and speed feedback (RPM)
    input wire logic signed [15:0] analog_speed_cmd,
    input wire logic signed [15:0] actual_speed,
    // Sequence inputs and outputs
    input wire scc_seq_in_t seq_in,
    output scc_seq_out_t seq_out,
    // Speed loop outputs
    output logic signed [15:0] speed_target,
    output logic [15:0] ext_speed_limit
);

    // ==========================================================
    // Registers
    logic [15:0] ctrl;
    logic [15:0] gain;
    logic [15:0] zclamp;
    logic [15:0] coin;
    logic [15:0] rot;
    logic [15:0] maxspd;

    function automatic logic [15:0] limit(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        limit = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [15:0] mag(input logic signed [16:0] v);
        logic signed [16:0] a;
        a = (v < 0) ? -v : v;
        mag = a[15:0];
    endfunction

    // ==========================================================
    // APB decode
    wire logic access = psel && penable && !pready;
    wire logic done = psel && penable && pready;
    wire logic wr = done && pwrite;
    wire logic [15:0] wd = pwdata[15:0];
    wire logic hit = (paddr == OFS_CTRL) || (paddr == OFS_GAIN) ||
        (paddr == OFS_ZCLAMP) || (paddr == OFS_COIN) ||
        (paddr == OFS_ROT) || (paddr == OFS_MAXSPD) ||
        (paddr == OFS_STATUS) || (paddr == OFS_TARGET);
    wire logic [31:0] rd_word =
        (paddr == OFS_CTRL) ? {16'h0000, ctrl} :
        (paddr == OFS_GAIN) ? {16'h0000, gain} :
        (paddr == OFS_ZCLAMP) ? {16'h0000, zclamp} :
        (paddr == OFS_COIN) ? {16'h0000, coin} :
        (paddr == OFS_ROT) ? {16'h0000, rot} :
        (paddr == OFS_MAXSPD) ? {16'h0000, maxspd} :
        (paddr == OFS_STATUS) ? {28'h0000000, seq_out} :
        (paddr == OFS_TARGET) ? {{16{speed_target[15]}}, speed_target} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access && !hit;
            if (access && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // Out-of-range GAIN, ZCLAMP, COIN and ROT writes saturate to the legal range; CTRL and MAXSPD take the value as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            gain <= GAIN_RST;
            zclamp <= ZCLAMP_RST;
            coin <= COIN_RST;
            rot <= ROT_RST;
            maxspd <= MAXSPD_RST;
        end else if (wr) begin
            case (paddr)
                OFS_CTRL: ctrl <= wd;
                OFS_GAIN: gain <= limit(wd, GAIN_MIN, GAIN_MAX);
                OFS_ZCLAMP: zclamp <= limit(wd, ZCLAMP_MIN, ZCLAMP_MAX);
                OFS_COIN: coin <= limit(wd, COIN_MIN, COIN_MAX);
                OFS_ROT: rot <= limit(wd, ROT_MIN, ROT_MAX);
                OFS_MAXSPD: maxspd <= wd;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Command scaling
    wire logic speed_mode = ctrl[CTRL_SPEED_MODE];
    wire logic [3:0] zc_code = ctrl[CTRL_ZC_LSB +: CTRL_ZC_W];
    // Operands widened first so the product cannot wrap
    wire logic signed [33:0] product =
        34'(analog_speed_cmd) * $signed({18'h00000, gain});
    wire logic signed [33:0] scaled_wide = product / SCALE_DIV;
    wire logic signed [16:0] scaled = 17'(scaled_wide);
    wire logic [15:0] scaled_mag = mag(scaled);

    // ==========================================================
    // Clamp, invert, gate
    wire logic zc_active = (zc_code == ZC_ALWAYS) ? 1'b1 :
        (zc_code == ZC_NEVER) ? 1'b0 : seq_in.zero_clamp_input;
    wire logic clamped = zc_active && (scaled_mag <= zclamp);
    wire logic invert = ctrl[CTRL_INV_ALLOC] &&
        seq_in.dir_invert_input;
    wire logic signed [16:0] clamped_cmd = clamped ? 17'sd0 : scaled;
    wire logic signed [16:0] cond_cmd =
        invert ? 17'(-clamped_cmd) : clamped_cmd;
    wire logic run_ok = seq_in.servo_on &&
        (!ctrl[CTRL_RUN_ALLOC] || seq_in.run_enable_input);
    wire logic signed [16:0] next_target =
        (speed_mode && run_ok) ? cond_cmd : 17'sd0;

    // ==========================================================
    // Status comparisons
    wire logic signed [16:0] actual_ext = 17'(actual_speed);
    wire logic signed [17:0] err = 18'(cond_cmd) - 18'(actual_ext);
    wire logic [17:0] err_abs = (err < 0) ? 18'(-err) : 18'(err);
    wire logic next_coin = ctrl[CTRL_COIN_ALLOC] &&
        (err_abs <= 18'(coin));
    wire logic next_rot = ctrl[CTRL_ROT_ALLOC] &&
        (mag(actual_ext) > rot);
    wire logic next_osc = speed_mode && (scaled_mag > maxspd);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_out <= '0;
            speed_target <= 16'sh0000;
            ext_speed_limit <= 16'h0000;
        end else begin
            seq_out.speed_coincidence_out <= next_coin;
            seq_out.line_indication_1 <= next_coin;
            seq_out.rotation_detect_out <= next_rot;
            seq_out.over_speed_command_warning <= next_osc;
            speed_target <= 16'(next_target);
            ext_speed_limit <= speed_mode ? 16'h0000 : scaled_mag;
        end
    end

endmodule

// *** testbench/scc_host_model.sv ***
/* Host side of the analog speed command.
   Assumes the bench names the wanted command in millivolts. */
`timescale 1ns/1ns
module scc_host_model
    import scc_pkg::*;
(
    // Clock and request
    input wire logic pclk,
    input wire logic signed [15:0] want_mv,
    // Analog command
    output logic signed [15:0] analog_speed_cmd
);
    // ==========================================================
    // Command source, kept within plus and minus ten volts
    initial analog_speed_cmd = 16'sh0;
    always @(posedge pclk) begin
        if (want_mv > 16'sd10000) begin
            analog_speed_cmd <= 16'sd10000;
        end else if (want_mv < -16'sd10000) begin
            analog_speed_cmd <= -16'sd10000;
        end else begin
            analog_speed_cmd <= want_mv;
        end
    end
endmodule

// *** testbench/scc_speed_cmd_assertions.sv ***
/* Port checker of the speed command block.
   Assumes a bind from the bench top; sees top ports only. */
`timescale 1ns/1ns
module scc_speed_cmd_checker
    import scc_pkg::*;
(
    // Watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input logic pready,
    input logic pslverr,
    input wire logic signed [15:0] analog_speed_cmd,
    input wire logic signed [15:0] actual_speed,
    input scc_seq_out_t seq_out,
    input logic signed [15:0] speed_target,
    input logic [15:0] ext_speed_limit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Bus and status relations
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready held");
    a_ready_answer: assert property (
        psel && penable && !pready |=> pready) else $error("no answer");
    a_err_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
    a_line_coin: assert property (
        seq_out.line_indication_1 == seq_out.speed_coincidence_out)
        else $error("line one differs");
    a_zero_target: assert property (
        $past(analog_speed_cmd) == 16'sh0 |-> speed_target == 16'sh0)
        else $error("target from zero");
    a_rot_motion: assert property (
        seq_out.rotation_detect_out |-> $past(actual_speed) != 16'sh0)
        else $error("rotation at rest");
    a_limit_mode: assert property (
        speed_target != 16'sh0 |-> ext_speed_limit == 16'h0)
        else $error("limit in speed mode");
    a_warn_cmd: assert property (
        seq_out.over_speed_command_warning |->
        $past(analog_speed_cmd) != 16'sh0) else $error("warn at zero");
endmodule

// *** testbench/speed_command_conditioning_tb.sv ***
/* Self-checking bench of the speed command block.
   Assumes APB access and the host model beside it. */
`timescale 1ns/1ns
module speed_command_conditioning_tb
    import scc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] q, ext_speed_limit;
    logic signed [15:0] want_mv, cmd, actual_speed, speed_target;
    scc_seq_in_t seq_in;
    scc_seq_out_t seq_out;
    int fail_count, samples_checked;
    always #5 pclk = ~pclk;
    scc_host_model host_u (.pclk(pclk), .want_mv(want_mv),
        .analog_speed_cmd(cmd));
    scc_speed_cmd dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_speed_cmd(cmd),
        .actual_speed(actual_speed), .seq_in(seq_in), .seq_out(seq_out),
        .speed_target(speed_target), .ext_speed_limit(ext_speed_limit));
    // ==========================================================
    // Tasks
    task give_verdict;
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1) begin
            fail_count++;
            give_verdict;
        end else begin
            q = prdata[15:0];
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic drive(input int mv, input int act);
        want_mv <= 16'(mv);
        actual_speed <= 16'(act);
        repeat (3) @(posedge pclk);
    endtask
    // ==========================================================
    // Sequence
    logic [7:0] ofs [4] = '{OFS_GAIN, OFS_ZCLAMP, OFS_COIN, OFS_ROT};
    logic [15:0] rv [4] = '{16'h1388, 16'h0, 16'ha, 16'h14};
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; want_mv = 0; actual_speed = 0; seq_in = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(0, ofs[i], 0);
            chk(q, rv[i]);
        end
        apb(0, 8'h40, 0);
        chk({15'h0, err}, 16'h1);
        chk(q, 16'h0);
        apb(1, OFS_GAIN, 16'h1);
        apb(0, OFS_GAIN, 0);
        chk(q, 16'h64);
        apb(1, OFS_GAIN, 16'h1388);
        seq_in.servo_on <= 1'b1;
        drive(6000, 0);
        chk(speed_target, 16'd3000);
        chk(16'(seq_out), 16'h0);
        drive(-6000, 0);
        chk(speed_target, -16'sd3000);
        apb(1, OFS_CTRL, 16'h1b);
        seq_in.dir_invert_input <= 1'b1;
        drive(6000, -2990);
        chk(speed_target, -16'sd3000);
        chk(16'(seq_out), 16'hd);
        drive(6000, -3011);
        chk(16'(seq_out), 16'h4);
        drive(6000, 20);
        chk(16'(seq_out), 16'h0);
        apb(1, OFS_MAXSPD, 16'd2000);
        drive(6000, 21);
        chk(16'(seq_out), 16'h6);
        apb(0, OFS_STATUS, 0);
        chk(q, 16'h6);
        seq_in.dir_invert_input <= 1'b0;
        apb(1, OFS_CTRL, 16'h803);
        apb(1, OFS_ZCLAMP, 16'd3000);
        drive(6000, 0);
        chk(speed_target, 16'd0);
        drive(6002, 0);
        chk(speed_target, 16'd3001);
        seq_in.zero_clamp_input <= 1'b1;
        apb(1, OFS_CTRL, 16'h003);
        drive(6000, 0);
        chk(speed_target, 16'd3000);
        apb(1, OFS_CTRL, 16'h103);
        drive(6000, 0);
        chk(speed_target, 16'd0);
        apb(1, OFS_CTRL, 16'h005);
        drive(-10000, 0);
        chk(speed_target, 16'd0);
        seq_in.run_enable_input <= 1'b1;
        drive(-10000, 0);
        chk(speed_target, -16'sd5000);
        apb(0, OFS_TARGET, 0);
        chk(q, 16'hec78);
        apb(1, OFS_COIN, 16'h0);
        apb(0, OFS_COIN, 0);
        chk(q, 16'h1);
        apb(1, OFS_CTRL, 16'h0);
        drive(6000, 0);
        chk(speed_target, 16'd0);
        chk(ext_speed_limit, 16'd3000);
        give_verdict;
    end
endmodule
bind scc_speed_cmd scc_speed_cmd_checker chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .analog_speed_cmd(analog_speed_cmd),
    .actual_speed(actual_speed), .seq_out(seq_out),
    .speed_target(speed_target), .ext_speed_limit(ext_speed_limit));
